/* File: design/dcrb_bank.sv */
// Digitizer control register bank with readback and output bus control
//
// Contract
// - Manual calibration drives fine DAC from even or odd fine-offset field.
// - Single gain uses even value; multi gain uses even/odd per line parity.
// - Bits 9,8,7 power down converter, front end, whole chip when set.
// - Output enable 0 floats all twelve bus lines; 1 drives; resets to 1.
// - Control bit 5 selects single gain at 0, multiple gain at 1.
// - Timing select 11 uses start-line bit: 0 even first, 1 odd first.
// - Control bit 1 enables minimum output clip; enabled after reset.
// - Control bit 0 selects 0.8V range at 0, 1.0V at 1.
// - Test bit 8 removes half-scale offset at the gain amplifier.
// - Test bit 3 routes inputs to converter; bit 2 bypasses the sampler.
// - Eight polarity bits: 0 active low, 1 active high; end-of-scan high.
// - Clock bit 5 selects external pin at 0, internal converter clock at 1.
// - Clock bit 4: bias only during clamp at 0, always powered at 1.
// - Clock bit 3 at 1 runs with calibration window alone, no clamp.
// - Clock bit 2 derives phase two from pixel strobe, or both strobes.
// - Clock bit 1: phase three always on at 0, rejects reset at 1.
// - Clock bit 0 resets 1; set lets blanking force the black code.
// - Delay fields are 6, 9 and 8 bits; zeros minimum, ones maximum.
// - Readback bit 9 turns register readback off at 0, on at 1.
// - Readback bits 8:6 pick calibration registers; bits 5:0 a serial one.
// - Writing 1 to reset bit restores all defaults, then self-clears.
// - Readback puts selected 10-bit register on the upper ten bus lines.
// - Calibration select 000 uses bits 5:0; otherwise they are ignored.
// - Black-level target code is the 8-bit offset register value.
`timescale 1ns/1ps
`default_nettype none
module dcrb_bank (
   input  wire logic               ref_clk,            // 20 MHz clock
   input  wire logic               nrst,               // Sync reset, active low
   input  wire logic               clk_en,             // Freezes state when low
   input  wire dcrb_pkg::dcrb_wr_t wr,                 // Decoded serial write
   input  wire logic               manual_cal,         // Manual calibration mode
   input  wire logic               odd_line,           // Current line is odd
   input  wire logic [9:0]         auto_fine_value,    // Fine DAC from auto loop
   input  wire logic [7:0]         black_target_code,  // Offset register value
   input  wire logic [9:0]         low_reg_data,       // Lower serial reg readback
   input  wire logic [9:0]         cal_reg_data,       // Calibration reg readback
   input  wire logic [11:0]        conv_data,          // Converter output word
   input  wire logic [7:0]         raw_clk_inputs,     // Clock pins, polarity order
   output var dcrb_pkg::dcrb_ctl_t ctl,                // Decoded controls
   output logic [7:0]              clk_inputs_active,  // Active-high clock levels
   output logic                    clamp_active,       // Clamp window for bias
   output logic                    restore_bias_on,    // Restore bias powered
   output logic [5:0]              low_reg_select,     // Lower reg readback addr
   output logic [2:0]              cal_reg_select,     // Calibration readback sel
   output logic                    reset_low_regs,     // Soft reset to lower regs
   output logic [11:0]             digital_output_bus, // Output data
   output logic [11:0]             digital_output_bus_oe // Output enables
);
   import dcrb_pkg::*;

   typedef struct packed {
      dcrb_regs_t regs;
      logic [11:0] dout;
      logic        line_parity;
   } dcrb_state_t;

   dcrb_state_t s_q;
   dcrb_state_t s_d;
   logic [9:0]  sel_data;
   logic        rb_serial;
   logic        blank_active;

   localparam dcrb_regs_t REGS_RESET = '{
      fine_offset_even:      RST_FINE_OFFSET,
      fine_offset_odd:       RST_FINE_OFFSET,
      chip_control:          RST_CHIP_CONTROL,
      test_options:          RST_TEST_OPTIONS,
      input_polarity:        RST_POLARITY,
      clocking_options:      RST_CLOCKING,
      black_strobe_delay:    RST_DELAY,
      pixel_strobe_delay:    RST_DELAY,
      converter_clock_delay: RST_DELAY,
      readback_select:       RST_READBACK,
      soft_reset:            1'b0
   };

   // Polarity normalisation per clock input
   genvar gi;
   generate
      for (gi = 0; gi < NUM_POL; gi++) begin : g_pol
         assign clk_inputs_active[gi] = s_q.regs.input_polarity[gi] ? raw_clk_inputs[gi]
                                                                    : ~raw_clk_inputs[gi];
      end
   endgenerate

   assign blank_active = clk_inputs_active[POL_OUTPUT_BLANKING];
   assign clamp_active = s_q.regs.clocking_options[CLK_SINGLE_LINE]
                       ? clk_inputs_active[POL_CAL_WINDOW]
                       : clk_inputs_active[POL_CLAMP];
   assign restore_bias_on = s_q.regs.clocking_options[CLK_BIAS_ON] | clamp_active;

   assign rb_serial      = (s_q.regs.readback_select[RB_CAL_HI:RB_CAL_LO] == 3'h0);
   assign cal_reg_select = s_q.regs.readback_select[RB_CAL_HI:RB_CAL_LO];
   assign low_reg_select = s_q.regs.readback_select[RB_REG_HI:0];
   assign reset_low_regs = s_q.regs.soft_reset;

   // Readback selection among calibration, lower and upper registers
   always_comb begin
      sel_data = 10'h000;
      if (!rb_serial) begin
         sel_data = cal_reg_data;
      end else begin
         case (low_reg_select)
            ADDR_FINE_OFFSET_EVEN: sel_data = s_q.regs.fine_offset_even;
            ADDR_FINE_OFFSET_ODD:  sel_data = s_q.regs.fine_offset_odd;
            ADDR_CHIP_CONTROL:     sel_data = s_q.regs.chip_control;
            ADDR_TEST_OPTIONS:     sel_data = s_q.regs.test_options;
            ADDR_INPUT_POLARITY:   sel_data = s_q.regs.input_polarity;
            ADDR_CLOCKING_OPTIONS: sel_data = s_q.regs.clocking_options;
            ADDR_BLACK_DELAY:      sel_data = s_q.regs.black_strobe_delay;
            ADDR_PIXEL_DELAY:      sel_data = s_q.regs.pixel_strobe_delay;
            ADDR_CONV_DELAY:       sel_data = s_q.regs.converter_clock_delay;
            ADDR_READBACK_SELECT:  sel_data = s_q.regs.readback_select;
            ADDR_SOFT_RESET:       sel_data = {9'h000, s_q.regs.soft_reset};
            default: begin
               sel_data = (low_reg_select < ADDR_FINE_OFFSET_EVEN) ? low_reg_data : 10'h000;
            end
         endcase
      end
   end

   always_comb begin
      s_d = s_q;
      if (s_q.regs.soft_reset) begin
         s_d.regs = REGS_RESET;
      end else if (wr.valid) begin
         case (wr.addr)
            ADDR_FINE_OFFSET_EVEN: s_d.regs.fine_offset_even = wr.data;
            ADDR_FINE_OFFSET_ODD:  s_d.regs.fine_offset_odd = wr.data;
            ADDR_CHIP_CONTROL:     s_d.regs.chip_control = wr.data & MASK_CHIP_CONTROL;
            // Reserved bits other than bit 9 are stored as written; host keeps them intact
            ADDR_TEST_OPTIONS:     s_d.regs.test_options = wr.data & MASK_TEST;
            ADDR_INPUT_POLARITY:   s_d.regs.input_polarity = wr.data & MASK_POLARITY;
            ADDR_CLOCKING_OPTIONS: s_d.regs.clocking_options = wr.data & MASK_CLOCKING;
            ADDR_BLACK_DELAY:      s_d.regs.black_strobe_delay = wr.data & MASK_BLACK_DELAY;
            ADDR_PIXEL_DELAY:      s_d.regs.pixel_strobe_delay = wr.data & MASK_PIXEL_DELAY;
            ADDR_CONV_DELAY:       s_d.regs.converter_clock_delay = wr.data & MASK_CONV_DELAY;
            ADDR_READBACK_SELECT:  s_d.regs.readback_select = wr.data;
            ADDR_SOFT_RESET:       s_d.regs.soft_reset = wr.data[SOFT_RESET_BIT];
            default: ;
         endcase
      end
      // Line parity: copies odd_line when it differs; at frame sync loads start bit when timing select is 11, else clears
      if (clk_inputs_active[POL_FRAME_SYNC]) begin
         s_d.line_parity = (s_q.regs.chip_control[CTL_MG_SEL_HI:CTL_MG_SEL_LO]
                            == MG_SEL_START_PARITY) ? s_q.regs.chip_control[CTL_START_ODD]
                                                    : 1'b0;
      end else if (odd_line != s_q.line_parity && !clk_inputs_active[POL_FRAME_SYNC]) begin
         s_d.line_parity = odd_line;
      end
      // Output word: readback, black clamp, or converter data
      if (s_q.regs.readback_select[RB_ON]) begin
         s_d.dout = {sel_data, 2'b00};
      end else if (s_q.regs.clocking_options[CLK_BLACK_CLAMP] && blank_active) begin
         s_d.dout = {4'h0, black_target_code};
      end else begin
         s_d.dout = conv_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         s_q.regs        <= REGS_RESET;
         s_q.dout        <= 12'h000;
         s_q.line_parity <= 1'b0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // Fine DAC choice and control decode
   always_comb begin
      ctl = '0;
      if (manual_cal) begin
         ctl.fine_dac_value = (s_q.regs.chip_control[CTL_MULTI_GAIN] && odd_line)
                            ? s_q.regs.fine_offset_odd
                            : s_q.regs.fine_offset_even;
      end else begin
         ctl.fine_dac_value = auto_fine_value;
      end
      ctl.converter_power_down      = s_q.regs.chip_control[CTL_CONV_PD];
      ctl.front_end_power_down      = s_q.regs.chip_control[CTL_FE_PD];
      ctl.whole_chip_power_down     = s_q.regs.chip_control[CTL_CHIP_PD];
      ctl.multi_gain_enable         = s_q.regs.chip_control[CTL_MULTI_GAIN];
      ctl.multi_gain_timing_select  = s_q.regs.chip_control[CTL_MG_SEL_HI:CTL_MG_SEL_LO];
      ctl.start_line_parity         = s_q.regs.chip_control[CTL_START_ODD];
      ctl.low_clip_enable           = s_q.regs.chip_control[CTL_LOW_CLIP];
      ctl.wide_input_range          = s_q.regs.chip_control[CTL_WIDE_RANGE];
      ctl.half_scale_offset_disable = s_q.regs.test_options[TST_HALF_SCALE_OFF];
      ctl.converter_direct_input    = s_q.regs.test_options[TST_CONV_DIRECT];
      ctl.sampler_bypass            = s_q.regs.test_options[TST_SAMPLER_BYPASS];
      ctl.converter_clock_source    = s_q.regs.clocking_options[CLK_CONV_SRC];
      ctl.restore_bias_always_on    = s_q.regs.clocking_options[CLK_BIAS_ON];
      ctl.single_line_signal_timing = s_q.regs.clocking_options[CLK_SINGLE_LINE];
      ctl.phase_two_source          = s_q.regs.clocking_options[CLK_PHASE_TWO];
      ctl.reset_pulse_rejection     = s_q.regs.clocking_options[CLK_RST_REJECT];
      ctl.black_strobe_delay_field    = s_q.regs.black_strobe_delay[5:0];
      ctl.pixel_strobe_delay_field    = s_q.regs.pixel_strobe_delay[8:0];
      ctl.converter_clock_delay_field = s_q.regs.converter_clock_delay[7:0];
   end

   // Bus drive follows the enable bit alone
   assign digital_output_bus    = s_q.dout;
   assign digital_output_bus_oe = {12{s_q.regs.chip_control[CTL_OUT_EN]}};
endmodule
`default_nettype wire

/* File: pkg/dcrb_pkg.sv */
// Package for the digitizer control register bank: addresses, fields, resets, types
package dcrb_pkg;
   // Serial register numbers
   localparam logic [5:0] ADDR_FINE_OFFSET_EVEN = 6'h0F;
   localparam logic [5:0] ADDR_FINE_OFFSET_ODD  = 6'h10;
   localparam logic [5:0] ADDR_CHIP_CONTROL     = 6'h11;
   localparam logic [5:0] ADDR_TEST_OPTIONS     = 6'h12;
   localparam logic [5:0] ADDR_INPUT_POLARITY   = 6'h13;
   localparam logic [5:0] ADDR_CLOCKING_OPTIONS = 6'h14;
   localparam logic [5:0] ADDR_BLACK_DELAY      = 6'h15;
   localparam logic [5:0] ADDR_PIXEL_DELAY      = 6'h16;
   localparam logic [5:0] ADDR_CONV_DELAY       = 6'h17;
   localparam logic [5:0] ADDR_READBACK_SELECT  = 6'h3E;
   localparam logic [5:0] ADDR_SOFT_RESET       = 6'h3F;

   // Reset values
   localparam logic [9:0] RST_FINE_OFFSET  = 10'h000;
   localparam logic [9:0] RST_CHIP_CONTROL = 10'h042;
   localparam logic [9:0] RST_TEST_OPTIONS = 10'h020;
   localparam logic [9:0] RST_POLARITY     = 10'h040;
   localparam logic [9:0] RST_CLOCKING     = 10'h001;
   localparam logic [9:0] RST_DELAY        = 10'h000;
   localparam logic [9:0] RST_READBACK     = 10'h000;

   // Writable bit masks
   localparam logic [9:0] MASK_CHIP_CONTROL = 10'h3FF;
   localparam logic [9:0] MASK_TEST         = 10'h1FF;
   localparam logic [9:0] MASK_POLARITY     = 10'h0FF;
   localparam logic [9:0] MASK_CLOCKING     = 10'h03F;
   localparam logic [9:0] MASK_BLACK_DELAY  = 10'h03F;
   localparam logic [9:0] MASK_PIXEL_DELAY  = 10'h1FF;
   localparam logic [9:0] MASK_CONV_DELAY   = 10'h0FF;

   // Chip control fields
   localparam int CTL_CONV_PD    = 9;
   localparam int CTL_FE_PD      = 8;
   localparam int CTL_CHIP_PD    = 7;
   localparam int CTL_OUT_EN     = 6;
   localparam int CTL_MULTI_GAIN = 5;
   localparam int CTL_MG_SEL_HI  = 4;
   localparam int CTL_MG_SEL_LO  = 3;
   localparam int CTL_START_ODD  = 2;
   localparam int CTL_LOW_CLIP   = 1;
   localparam int CTL_WIDE_RANGE = 0;
   localparam logic [1:0] MG_SEL_START_PARITY = 2'h3;

   // Test fields
   localparam int TST_HALF_SCALE_OFF = 8;
   localparam int TST_CONV_DIRECT    = 3;
   localparam int TST_SAMPLER_BYPASS = 2;

   // Clocking fields
   localparam int CLK_CONV_SRC    = 5;
   localparam int CLK_BIAS_ON     = 4;
   localparam int CLK_SINGLE_LINE = 3;
   localparam int CLK_PHASE_TWO   = 2;
   localparam int CLK_RST_REJECT  = 1;
   localparam int CLK_BLACK_CLAMP = 0;

   // Readback fields
   localparam int RB_ON     = 9;
   localparam int RB_CAL_HI = 8;
   localparam int RB_CAL_LO = 6;
   localparam int RB_REG_HI = 5;
   localparam int SOFT_RESET_BIT = 0;

   // Polarity bit order
   localparam int POL_OUTPUT_BLANKING = 7;
   localparam int POL_END_OF_SCAN     = 6;
   localparam int POL_BLACK_STROBE    = 5;
   localparam int POL_PIXEL_STROBE    = 4;
   localparam int POL_CAL_WINDOW      = 3;
   localparam int POL_CLAMP           = 2;
   localparam int POL_FRAME_SYNC      = 1;
   localparam int POL_CONV_CLOCK      = 0;
   localparam int NUM_POL             = 8;

   typedef struct packed {
      logic [9:0] fine_offset_even;
      logic [9:0] fine_offset_odd;
      logic [9:0] chip_control;
      logic [9:0] test_options;
      logic [9:0] input_polarity;
      logic [9:0] clocking_options;
      logic [9:0] black_strobe_delay;
      logic [9:0] pixel_strobe_delay;
      logic [9:0] converter_clock_delay;
      logic [9:0] readback_select;
      logic       soft_reset;
   } dcrb_regs_t;

   // Serial write strobe with register number and data
   typedef struct packed {
      logic       valid;
      logic [5:0] addr;
      logic [9:0] data;
   } dcrb_wr_t;

   // Decoded analog/timing controls
   typedef struct packed {
      logic [9:0] fine_dac_value;
      logic       converter_power_down;
      logic       front_end_power_down;
      logic       whole_chip_power_down;
      logic       multi_gain_enable;
      logic [1:0] multi_gain_timing_select;
      logic       start_line_parity;
      logic       low_clip_enable;
      logic       wide_input_range;
      logic       half_scale_offset_disable;
      logic       converter_direct_input;
      logic       sampler_bypass;
      logic       converter_clock_source;
      logic       restore_bias_always_on;
      logic       single_line_signal_timing;
      logic       phase_two_source;
      logic       reset_pulse_rejection;
      logic [5:0] black_strobe_delay_field;
      logic [8:0] pixel_strobe_delay_field;
      logic [7:0] converter_clock_delay_field;
   } dcrb_ctl_t;
endpackage

/* File: testbench/dcrb_bank_assertions.sv */
// Port checker for the register bank
`timescale 1ns/1ps
`default_nettype none
module dcrb_bank_chk (
   input wire logic               ref_clk,               // Clock
   input wire logic               nrst,                  // Reset
   input wire logic               clk_en,                // Enable
   input wire dcrb_pkg::dcrb_wr_t  wr,                    // Write
   input wire logic               manual_cal,            // Manual mode
   input wire logic [9:0]         auto_fine_value,       // Auto value
   input wire dcrb_pkg::dcrb_ctl_t ctl,                   // Controls
   input wire logic [7:0]         clk_inputs_active,     // Levels
   input wire logic               clamp_active,          // Clamp
   input wire logic               restore_bias_on,       // Bias
   input wire logic [5:0]         low_reg_select,        // Serial select
   input wire logic [2:0]         cal_reg_select,        // Cal select
   input wire logic               reset_low_regs,        // Reset pulse
   input wire logic [11:0]        digital_output_bus_oe  // Enables
);
   import dcrb_pkg::*;
   logic wr_ok;
   logic ctl_w;
   assign wr_ok = nrst && clk_en && wr.valid && !reset_low_regs;
   assign ctl_w = wr_ok && wr.addr == ADDR_CHIP_CONTROL;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   power_bits_a:
      assert property (ctl_w |=> {ctl.converter_power_down, ctl.front_end_power_down,
         ctl.whole_chip_power_down} == $past(wr.data[9:7])) else $error("power bits wrong");
   drive_enable_a:
      assert property (ctl_w |=> digital_output_bus_oe == {12{$past(wr.data[6])}})
         else $error("drive enable wrong");
   gain_mode_a:
      assert property (ctl_w |=> ctl.multi_gain_enable == $past(wr.data[5])
         && ctl.start_line_parity == $past(wr.data[2])) else $error("gain mode wrong");
   delay_field_a:
      assert property (wr_ok && wr.addr == ADDR_PIXEL_DELAY |=> ctl.pixel_strobe_delay_field
         == $past(wr.data[8:0])) else $error("pixel delay wrong");
   readback_sel_a:
      assert property (wr_ok && wr.addr == ADDR_READBACK_SELECT |=> {cal_reg_select,
         low_reg_select} == $past(wr.data[8:0])) else $error("readback select wrong");
   soft_pulse_a:
      assert property (wr_ok && wr.addr == ADDR_SOFT_RESET && wr.data[0] |=> reset_low_regs)
         else $error("soft reset pulse missing");
   soft_restore_a:
      assert property (reset_low_regs && clk_en |=> !reset_low_regs && low_reg_select == 6'h00
         && digital_output_bus_oe == 12'hFFF) else $error("soft reset incomplete");
   fine_auto_a:
      assert property (!manual_cal |-> ctl.fine_dac_value == auto_fine_value)
         else $error("fine value wrong");
   clamp_window_a:
      assert property (clamp_active == (ctl.single_line_signal_timing ? clk_inputs_active[3]
         : clk_inputs_active[2])) else $error("clamp window wrong");
   restore_bias_a:
      assert property (restore_bias_on == (ctl.restore_bias_always_on || clamp_active))
         else $error("restore bias wrong");
endmodule
bind dcrb_bank dcrb_bank_chk u_dcrb_bank_chk (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
   .wr(wr), .manual_cal(manual_cal), .auto_fine_value(auto_fine_value), .ctl(ctl),
   .clk_inputs_active(clk_inputs_active), .clamp_active(clamp_active),
   .restore_bias_on(restore_bias_on), .low_reg_select(low_reg_select),
   .cal_reg_select(cal_reg_select), .reset_low_regs(reset_low_regs),
   .digital_output_bus_oe(digital_output_bus_oe));
`default_nettype wire

/* File: testbench/dcrb_bank_bench.sv */
// Self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module dcrb_bank_bench;
   import dcrb_pkg::*;
   logic        ref_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        en = 1'b1;
   logic        manual_cal = 1'b0;
   logic        odd_line = 1'b0;
   logic [7:0]  raw = 8'h00;
   logic [11:0] conv = 12'hABC;
   dcrb_wr_t    wr;
   dcrb_ctl_t   ctl;
   logic [7:0]  act;
   logic        clamp;
   logic        bias;
   logic        rlr;
   logic [5:0]  lsel;
   logic [2:0]  csel;
   logic [11:0] dob;
   logic [11:0] oe;
   logic [5:0]  cfld;
   logic [7:0]  tfld;
   int          error_cnt = 0;
   int          comparisons = 0;
   int          cyc = 0;
   logic [5:0]  adr [9] = '{6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17};
   logic [9:0]  rst [9] = '{RST_FINE_OFFSET, RST_FINE_OFFSET, RST_CHIP_CONTROL,
      RST_TEST_OPTIONS, RST_POLARITY, RST_CLOCKING, RST_DELAY, RST_DELAY, RST_DELAY};
   logic [9:0]  msk [9] = '{10'h3FF, 10'h3FF, MASK_CHIP_CONTROL, MASK_TEST, MASK_POLARITY,
      MASK_CLOCKING, MASK_BLACK_DELAY, MASK_PIXEL_DELAY, MASK_CONV_DELAY};
   logic [7:0]  pol [3] = '{8'h00, 8'hFF, 8'h80};
   assign cfld = {ctl.converter_power_down, ctl.front_end_power_down,
      ctl.whole_chip_power_down, ctl.multi_gain_enable, ctl.low_clip_enable, ctl.wide_input_range};
   assign tfld = {ctl.half_scale_offset_disable, ctl.converter_direct_input, ctl.sampler_bypass,
      ctl.converter_clock_source, ctl.restore_bias_always_on, ctl.single_line_signal_timing,
      ctl.phase_two_source, ctl.reset_pulse_rejection};
   dcrb_host u_dcrb_host (.ref_clk(ref_clk), .wr(wr));
   dcrb_bank u_dcrb_bank (.ref_clk(ref_clk), .nrst(nrst), .clk_en(en), .wr(wr),
      .manual_cal(manual_cal), .odd_line(odd_line), .auto_fine_value(10'h3C3),
      .black_target_code(8'h5E), .low_reg_data(10'h2B5), .cal_reg_data(10'h1C7),
      .conv_data(conv), .raw_clk_inputs(raw), .ctl(ctl), .clk_inputs_active(act),
      .clamp_active(clamp), .restore_bias_on(bias), .low_reg_select(lsel),
      .cal_reg_select(csel), .reset_low_regs(rlr), .digital_output_bus(dob),
      .digital_output_bus_oe(oe));
   always #25 ref_clk = ~ref_clk;
   task automatic print_verdict();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd(input logic [5:0] a, input logic [9:0] exp);
      u_dcrb_host.write(ADDR_READBACK_SELECT, {4'h8, a});
      @(posedge ref_clk);
      #2 chk(dob, {exp, 2'h0}, "readback");
   endtask
   initial begin
      logic [9:0] p;
      logic [9:0] e;
      repeat (12) @(posedge ref_clk);
      #2 nrst = 1'b1;
      for (int i = 0; i < 9; i++) rd(adr[i], rst[i]);
      for (int k = 0; k < 2; k++) begin
         p = k ? 10'h000 : 10'h3FF;
         for (int i = 0; i < 9; i++) begin
            u_dcrb_host.write(adr[i], p);
            e = (adr[i] == ADDR_TEST_OPTIONS) ? (p & ~10'h0F3) | (RST_TEST_OPTIONS & 10'h0F3) : p;
            rd(adr[i], e & msk[i]);
         end
         chk({6'h0, cfld}, {6'h0, {6{p[0]}}}, "chip fields");
         chk({9'h0, ctl.start_line_parity, ctl.multi_gain_timing_select},
            {9'h0, {3{p[0]}}}, "timing");
         chk({4'h0, tfld}, {4'h0, {8{p[0]}}}, "modes");
         chk({3'h0, ctl.pixel_strobe_delay_field}, {3'h0, {9{p[0]}}}, "delay");
         chk({ctl.black_strobe_delay_field, 6'h0}, {{6{p[0]}}, 6'h0}, "black delay");
         chk({4'h0, ctl.converter_clock_delay_field}, {4'h0, {8{p[0]}}}, "conv delay");
         chk(oe, {12{p[0]}}, "drive enable");
      end
      u_dcrb_host.write(ADDR_FINE_OFFSET_EVEN, 10'h155);
      u_dcrb_host.write(ADDR_FINE_OFFSET_ODD, 10'h2AA);
      u_dcrb_host.write(ADDR_CHIP_CONTROL, 10'h040);
      manual_cal = 1'b1;
      odd_line = 1'b1;
      #1 chk({2'h0, ctl.fine_dac_value}, 12'h155, "fine value");
      u_dcrb_host.write(ADDR_CHIP_CONTROL, 10'h060);
      #1 chk({2'h0, ctl.fine_dac_value}, 12'h2AA, "fine value");
      odd_line = 1'b0;
      #1 chk({2'h0, ctl.fine_dac_value}, 12'h155, "fine value");
      foreach (pol[j]) begin
         u_dcrb_host.write(ADDR_INPUT_POLARITY, {2'h0, pol[j]});
         raw = pol[j] ^ 8'h3C;
         #1 chk({4'h0, act}, 12'h0C3, "active levels");
      end
      raw = 8'h84;
      u_dcrb_host.write(ADDR_CLOCKING_OPTIONS, 10'h008);
      chk({10'h0, clamp, bias}, 12'h003, "clamp window");
      u_dcrb_host.write(ADDR_CLOCKING_OPTIONS, 10'h001);
      chk({10'h0, clamp, bias}, 12'h000, "clamp window");
      u_dcrb_host.write(ADDR_READBACK_SELECT, 10'h000);
      @(posedge ref_clk);
      #2 chk(dob, 12'h05E, "blanked bus");
      u_dcrb_host.write(ADDR_CLOCKING_OPTIONS, 10'h000);
      @(posedge ref_clk);
      #2 chk(dob, conv, "converter bus");
      u_dcrb_host.write(ADDR_READBACK_SELECT, 10'h27F);
      @(posedge ref_clk);
      #2 chk(dob, {10'h1C7, 2'h0}, "cal readback");
      chk({9'h0, csel}, 12'h001, "cal select");
      rd(6'h05, 10'h2B5);
      chk({6'h0, lsel}, 12'h005, "serial select");
      u_dcrb_host.write(6'h20, 10'h3FF);
      rd(6'h20, 10'h000);
      en = 1'b0;
      u_dcrb_host.write(ADDR_CHIP_CONTROL, 10'h000);
      en = 1'b1;
      rd(ADDR_CHIP_CONTROL, 10'h060);
      u_dcrb_host.write(ADDR_SOFT_RESET, 10'h001);
      chk({11'h0, rlr}, 12'h001, "reset pulse");
      @(posedge ref_clk);
      #2 chk({11'h0, rlr}, 12'h000, "reset pulse");
      rd(ADDR_CHIP_CONTROL, RST_CHIP_CONTROL);
      rd(ADDR_SOFT_RESET, 10'h000);
      print_verdict();
   end
endmodule
`default_nettype wire

/* File: testbench/dcrb_host.sv */
// Host model: writes serial registers of the register bank
`timescale 1ns/1ps
`default_nettype none
module dcrb_host (
   input  wire logic              ref_clk, // Clock
   output var  dcrb_pkg::dcrb_wr_t wr      // Write strobe
);
   import dcrb_pkg::*;
   logic [9:0] test_shadow_q;
   initial begin
      wr = '0;
      test_shadow_q = RST_TEST_OPTIONS;
   end
   task automatic write(input logic [5:0] a, input logic [9:0] d);
      logic [9:0] v;
      v = d;
      if (a == ADDR_TEST_OPTIONS) begin
         v = (d & ~10'h0F3) | (test_shadow_q & 10'h0F3);
         test_shadow_q = v;
      end
      if (a == ADDR_SOFT_RESET && d[0]) begin
         test_shadow_q = RST_TEST_OPTIONS;
      end
      @(posedge ref_clk);
      #2 wr = '{1'b1, a, v};
      @(posedge ref_clk);
      #2 wr.valid = 1'b0;
   endtask
endmodule
`default_nettype wire
